//--- design/auto_rdi_control.v
// auto_rdi_control.v: automatic line, path and enhanced path rdi decisions
// assumes: alarms come from synchronous detectors on aclk; frame_start is
// a one-cycle aclk pulse marking each transmit frame; axi4-lite on aclk.
// Notes on behaviour
// - signal fail enable inserts line rdi under master
// - signal degrade enable inserts line rdi under master
// - path rdi register drives g1 bit five
// - per-alarm path rdi enables, gated by master
// - los, lof or line ais raise path rdi
// - trace mismatch enhanced codes bit6 high bit7 low
// - trace unstable enhanced codes bit6 high bit7 low
// - label mismatch enhanced codes bit6 high bit7 low
// - cell delineation enhanced codes bit6 high bit7 low
// - enhanced enables idle while enhanced master low
// - disabled event never touches enhanced bits
// - concat pointer loss disable codes bit6 low bit7 high
// - pointer loss disable codes bit6 low bit7 high
// - path ais disable codes bit6 low bit7 high
// - line alarm disable codes bit6 low bit7 high
// - disable-class coding beats enable-class coding
// - disable bits low leave enable-class coding alone
// - enhanced master gates all enhanced insertion
// - unequipped enhanced codes bit6 high bit7 low
// - concat path ais disable codes bit6 low bit7 high
// - unequipped enable asserts path rdi
`timescale 1ns/1ps
`include "auto_rdi_regs.vh"

module auto_rdi_control (
  // clock, enable, reset
  input  wire        aclk,
  input  wire        clk_en,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // frame timing from the transmit side
  input  wire        frame_start,
  // receive alarms, levels
  input  wire        sf_ber_alarm,
  input  wire        sd_ber_alarm,
  input  wire        los_alarm,
  input  wire        lof_alarm,
  input  wire        line_ais_alarm,
  input  wire        trace_mismatch,
  input  wire        trace_unstable,
  input  wire        concat_pointer_loss,
  input  wire        pointer_loss,
  input  wire        signal_label_mismatch,
  input  wire        path_ais_alarm,
  input  wire        concat_path_ais,
  input  wire        cell_delineation_loss,
  input  wire        label_unequipped,
  // decisions toward the transmit overhead processors
  output reg         line_rdi_insert,
  output reg  [2:0]  g1_rdi_bits
);

  // software registers
  reg  [7:0] line_ctrl_ff;            // line rdi enables
  reg  [7:0] path_ctrl_ff;            // path rdi enables
  reg  [7:0] enh_ctrl_ff;             // enhanced enables and disables
  reg  [7:0] rx_enh_ff;               // concat, unequipped, enhanced master
  reg  [7:0] master_ff;               // auto line / auto path masters

  // write channel capture, either order accepted
  reg        aw_held_ff;              // write address taken
  reg  [7:0] aw_idx_ff;               // its register index
  reg        w_held_ff;               // write data taken
  reg  [7:0] w_data_ff;               // low byte of data
  reg        w_strb_ff;               // lane 0 strobe

  // combinational decisions
  reg        nxt_line_rdi;
  reg  [2:0] nxt_g1;
  reg        path_cause;
  reg        enh_enable_hit;
  reg        enh_disable_hit;
  reg  [31:0] rd_word;
  reg        rd_ok;

  wire       line_alarm_any;          // los or lof or line ais
  wire [7:0] ar_idx;
  wire       wr_fire;
  wire       wr_ok;

  assign line_alarm_any = los_alarm | lof_alarm | line_ais_alarm;
  assign ar_idx = s_axi_araddr[`ADDR_IDX_HI:`ADDR_IDX_LO];

  // one write at a time: stop taking until response is accepted
  assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  assign wr_ok = (aw_idx_ff == `IDX_LINE_RDI_CTRL) |
                 (aw_idx_ff == `IDX_AUTO_PATH_RDI) |
                 (aw_idx_ff == `IDX_AUTO_ENH_RDI) |
                 (aw_idx_ff == `IDX_RX_RDI_ENH) |
                 (aw_idx_ff == `IDX_MASTER_CTRL) |
                 (aw_idx_ff == `IDX_STATUS);

  // rdi decision logic from current alarm levels
  always @* begin
    // line rdi, only under the auto line master
    nxt_line_rdi = master_ff[`F_AUTO_LINE] &
      ((line_ctrl_ff[`F_SF_LINE] & sf_ber_alarm) |
       (line_ctrl_ff[`F_SD_LINE] & sd_ber_alarm));
    // any enabled path cause
    path_cause =
      (path_ctrl_ff[`F_TIM_P]    & trace_mismatch) |
      (path_ctrl_ff[`F_TIU_P]    & trace_unstable) |
      (path_ctrl_ff[`F_CONCAT_POINTER_LOSS_P] & concat_pointer_loss) |
      (path_ctrl_ff[`F_LOP_P]    & pointer_loss) |
      (path_ctrl_ff[`F_SIGNAL_LABEL_MISMATCH_P]   & signal_label_mismatch) |
      (path_ctrl_ff[`F_PAIS_P]   & path_ais_alarm) |
      (path_ctrl_ff[`F_LCD_P]    & cell_delineation_loss) |
      (path_ctrl_ff[`F_ALRM_P]   & line_alarm_any) |
      (rx_enh_ff[`F_CONCAT_PATH_AIS_P]   & concat_path_ais) |
      (rx_enh_ff[`F_UNEQ_P]      & label_unequipped);
    // disable-class events, each only when its bit is set
    enh_disable_hit =
      (enh_ctrl_ff[`F_NOLOPCON_E] & concat_pointer_loss) |
      (enh_ctrl_ff[`F_NOLOP_E]    & pointer_loss) |
      (enh_ctrl_ff[`F_NOPAIS_E]   & path_ais_alarm) |
      (enh_ctrl_ff[`F_NOALM_E]    & line_alarm_any) |
      (rx_enh_ff[`F_NOPAISCON_E]  & concat_path_ais);
    // enable-class events, gated per enable
    enh_enable_hit =
      (enh_ctrl_ff[`F_TIM_E]  & trace_mismatch) |
      (enh_ctrl_ff[`F_TIU_E]  & trace_unstable) |
      (enh_ctrl_ff[`F_SIGNAL_LABEL_MISMATCH_E] & signal_label_mismatch) |
      (enh_ctrl_ff[`F_LCD_E]  & cell_delineation_loss) |
      (rx_enh_ff[`F_UNEQ_E]   & label_unequipped);
    nxt_g1 = 3'h0;
    // path rdi bit under the auto path master
    nxt_g1[0] = master_ff[`F_AUTO_PATH] & path_cause;
    if (rx_enh_ff[`F_ENH_MASTER]) begin
      if (enh_disable_hit) begin
        // disable class wins over any enable-class request
        nxt_g1[1] = 1'b0;
        nxt_g1[2] = 1'b1;
      end else if (enh_enable_hit) begin
        // several enable-class events still give one coding
        nxt_g1[1] = 1'b1;
        nxt_g1[2] = 1'b0;
      end
    end
    // master low: enhanced bits stay zero, enables inert
    // an enable that is low contributes nothing above
  end

  // decisions latched at frame boundaries so g1 never changes mid-frame
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_rdi_insert <= 1'b0;
      g1_rdi_bits     <= 3'h0;
    end else if (clk_en && frame_start) begin
      line_rdi_insert <= nxt_line_rdi;
      g1_rdi_bits     <= nxt_g1;
    end
  end

  // write path: capture address and data, then commit together
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff   <= 1'b0;
      aw_idx_ff    <= 8'h00;
      w_held_ff    <= 1'b0;
      w_data_ff    <= 8'h00;
      w_strb_ff    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      line_ctrl_ff <= `RST_LINE_RDI_CTRL;
      path_ctrl_ff <= `RST_AUTO_PATH_RDI;
      enh_ctrl_ff  <= `RST_AUTO_ENH_RDI;
      rx_enh_ff    <= `RST_RX_RDI_ENH;
      master_ff    <= `RST_MASTER_CTRL;
    end else if (clk_en) begin
      // address channel
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff  <= s_axi_awaddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
      end
      // data channel
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_strb_ff <= s_axi_wstrb[0];
      end
      // commit and respond
      if (wr_fire) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (w_strb_ff) begin
          // only lane 0 carries register bits; status is read-only
          case (aw_idx_ff)
            `IDX_LINE_RDI_CTRL: line_ctrl_ff <= w_data_ff;
            `IDX_AUTO_PATH_RDI: path_ctrl_ff <= w_data_ff;
            `IDX_AUTO_ENH_RDI:  enh_ctrl_ff  <= w_data_ff;
            `IDX_RX_RDI_ENH:
              rx_enh_ff <= w_data_ff & `RX_RDI_ENH_MASK;
            `IDX_MASTER_CTRL:
              master_ff <= w_data_ff & `MASTER_CTRL_MASK;
            default: ;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux, unused bits read zero
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (ar_idx)
      `IDX_LINE_RDI_CTRL: rd_word[7:0] = line_ctrl_ff;
      `IDX_AUTO_PATH_RDI: rd_word[7:0] = path_ctrl_ff;
      `IDX_AUTO_ENH_RDI:  rd_word[7:0] = enh_ctrl_ff;
      `IDX_RX_RDI_ENH:    rd_word[7:0] = rx_enh_ff;
      `IDX_MASTER_CTRL:   rd_word[7:0] = master_ff;
      // live decisions: bit 3 line rdi, bits 2:0 g1 bits 7..5
      `IDX_STATUS:        rd_word[3:0] = {line_rdi_insert, g1_rdi_bits};
      default:            rd_ok = 1'b0;
    endcase
  end

  // read path: one cycle to data, held until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // auto_rdi_control

//--- design/auto_rdi_regs.vh
// auto_rdi_regs.vh: register map, field positions and reset values
// assumes: included by the auto rdi control block and its testbench top
`ifndef AUTO_RDI_REGS_VH
`define AUTO_RDI_REGS_VH

// printed offsets are register indices; byte address is four times these
`define IDX_LINE_RDI_CTRL    8'h08
`define IDX_AUTO_PATH_RDI    8'h09
`define IDX_AUTO_ENH_RDI     8'h0a
`define IDX_RX_RDI_ENH       8'h0b
`define IDX_MASTER_CTRL      8'h0c
`define IDX_STATUS           8'h0d

// index field of the byte address
`define ADDR_IDX_HI          9
`define ADDR_IDX_LO          2

// reset values
`define RST_LINE_RDI_CTRL    8'h32
`define RST_AUTO_PATH_RDI    8'h3f
`define RST_AUTO_ENH_RDI     8'h11
`define RST_RX_RDI_ENH       8'h03
`define RST_MASTER_CTRL      8'h00

// line rdi control fields
`define F_SD_LINE            7
`define F_SF_LINE            6
// auto path rdi fields
`define F_LCD_P              7
`define F_ALRM_P             6
`define F_PAIS_P             5
`define F_SIGNAL_LABEL_MISMATCH_P             4
`define F_LOP_P              3
`define F_CONCAT_POINTER_LOSS_P           2
`define F_TIU_P              1
`define F_TIM_P              0
// auto enhanced rdi fields
`define F_LCD_E              7
`define F_NOALM_E            6
`define F_NOPAIS_E           5
`define F_SIGNAL_LABEL_MISMATCH_E             4
`define F_NOLOP_E            3
`define F_NOLOPCON_E         2
`define F_TIU_E              1
`define F_TIM_E              0
// receive rdi / enhanced rdi fields
`define F_CONCAT_PATH_AIS_P          7
`define F_NOPAISCON_E        6
`define F_ENH_MASTER         2
`define F_UNEQ_P             1
`define F_UNEQ_E             0
`define RX_RDI_ENH_MASK      8'hc7
// master control fields
`define F_AUTO_LINE          0
`define F_AUTO_PATH          1
`define MASTER_CTRL_MASK     8'h03

// g1 byte bit positions for the rdi field
`define G1_BIT5              5
`define G1_BIT6              6
`define G1_BIT7              7

// axi responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

//--- verification/auto_rdi_chk.sv
// auto_rdi_chk.sv: port-level assertions for the auto rdi control block
// assumes: bound to auto_rdi_control; one clock, sync active-low reset
`timescale 1ns/1ps
module auto_rdi_chk (
  // clock, enable, reset
  input wire        aclk, clk_en, aresetn,
  // bus handshakes
  input wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // frame timing and alarms
  input wire        frame_start, sf_ber_alarm, sd_ber_alarm, los_alarm,
  input wire        lof_alarm, line_ais_alarm, trace_mismatch, trace_unstable,
  input wire        concat_pointer_loss, pointer_loss, signal_label_mismatch,
  input wire        path_ais_alarm, concat_path_ais, cell_delineation_loss,
  input wire        label_unequipped,
  // decisions
  input wire        line_rdi_insert,
  input wire [2:0]  g1_rdi_bits
);
  // causes that may code bit7 high, and those that may code bit6 high
  wire dis_cause = concat_pointer_loss | pointer_loss | path_ais_alarm |
                   los_alarm | lof_alarm | line_ais_alarm | concat_path_ais;
  wire en_cause  = trace_mismatch | trace_unstable | signal_label_mismatch |
                   cell_delineation_loss | label_unequipped;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // the one edge at which decisions are taken
  sequence frame_edge;
    frame_start && clk_en;
  endsequence

  chk_hold_frame: assert property (!(frame_start && clk_en) |=>
    $stable({line_rdi_insert, g1_rdi_bits})) else $error("decision moved");
  chk_quiet_clear: assert property (frame_edge ##0
    !(dis_cause | en_cause | sf_ber_alarm | sd_ber_alarm) |=>
    g1_rdi_bits == 3'h0 && !line_rdi_insert) else $error("rdi not released");
  chk_line_cause: assert property (frame_edge ##0
    !(sf_ber_alarm | sd_ber_alarm) |=> !line_rdi_insert)
    else $error("line rdi without cause");
  chk_bit7_cause: assert property (frame_edge ##0 !dis_cause |=>
    !g1_rdi_bits[2]) else $error("bit7 without cause");
  chk_bit6_cause: assert property (frame_edge ##0 !en_cause |=>
    !g1_rdi_bits[1]) else $error("bit6 without cause");
  chk_one_code: assert property (g1_rdi_bits[2] |->
    !g1_rdi_bits[1]) else $error("both codings high");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
    |=> s_axi_rvalid) else $error("read not answered");
  chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken during response");
endmodule // auto_rdi_chk

bind auto_rdi_control auto_rdi_chk u_auto_rdi_chk (.*);

//--- verification/far_end_g1_sink.sv
// far_end_g1_sink.sv: far terminal view of the transmitted g1 byte
// assumes: rdi decisions are levels that stand for a whole frame
`timescale 1ns/1ps
module far_end_g1_sink (
  // decisions from the block
  input  wire       line_rdi_insert,
  input  wire [2:0] g1_rdi_bits,
  // what the far end reads
  output wire [7:0] g1_byte,
  output wire       line_rdi_seen
);
  // rdi field in bits 7..5; low bits are not ours, shown zero
  assign g1_byte = {g1_rdi_bits[2], g1_rdi_bits[1], g1_rdi_bits[0], 5'h00};
  assign line_rdi_seen = line_rdi_insert;
endmodule // far_end_g1_sink

//--- verification/auto_rdi_control_tb_top.sv
// auto_rdi_control_tb_top.sv: register and frame tests of the rdi block
// assumes: 50 MHz aclk, sync active-low reset, axi4-lite slave on aclk
`timescale 1ns/1ps
`include "auto_rdi_regs.vh"
module auto_rdi_control_tb_top;
  reg         aclk = 1'b0, clk_en = 1'b1, aresetn = 1'b0;
  reg  [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0, frame_start = 1'b0;
  reg  [13:0] alm = 14'h0;       // alarm levels, packed
  reg  [7:0]  sh [0:4];          // shadow of indices 0x08..0x0c
  wire        awready, wready, bvalid, arready, rvalid, line, line_seen;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  g1;
  wire [7:0]  g1_byte;
  integer     mismatches = 0, check_count = 0, i, c;

  always #10 aclk = ~aclk;

  auto_rdi_control u_auto_rdi_control (
    .aclk(aclk), .clk_en(clk_en), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_start(frame_start),
    .sf_ber_alarm(alm[0]), .sd_ber_alarm(alm[1]), .los_alarm(alm[2]),
    .lof_alarm(alm[3]), .line_ais_alarm(alm[4]), .trace_mismatch(alm[5]),
    .trace_unstable(alm[6]), .concat_pointer_loss(alm[7]),
    .pointer_loss(alm[8]), .signal_label_mismatch(alm[9]),
    .path_ais_alarm(alm[10]), .concat_path_ais(alm[11]),
    .cell_delineation_loss(alm[12]), .label_unequipped(alm[13]),
    .line_rdi_insert(line), .g1_rdi_bits(g1));

  far_end_g1_sink u_far_end_g1_sink (.line_rdi_insert(line),
    .g1_rdi_bits(g1), .g1_byte(g1_byte), .line_rdi_seen(line_seen));

  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %s exp %h got %h", n, e, g);
      end
    end
  endtask

  // write; bready raised late so the response has to wait
  task wr(input [7:0] idx, input [7:0] d, input [1:0] er);
    integer n;
    begin
      awaddr <= {22'h0, idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        bready <= (n > 1);
        n = n + 1;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      chk("bresp", er, bresp);
    end
  endtask

  // read; rready raised late as well
  task rd(input [7:0] idx, input [7:0] e, input [1:0] er);
    integer n;
    begin
      araddr <= {22'h0, idx, 2'b00};
      arvalid <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        rready <= (n > 1);
        n = n + 1;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      chk("rdata", {24'h0, e}, rdata);
      chk("rresp", er, rresp);
    end
  endtask

  // expected g1 byte from shadow registers and alarms
  function [7:0] expb(input [13:0] a);
    reg p, d, e;
    begin
      p = sh[4][1] & |({sh[1], sh[3][7], sh[3][1]} & {a[12], |a[4:2],
          a[10], a[9], a[8], a[7], a[6], a[5], a[11], a[13]});
      d = sh[3][2] & |({sh[3][6], sh[2][6:5], sh[2][3:2]} &
          {a[11], |a[4:2], a[10], a[8], a[7]});
      e = sh[3][2] & |({sh[2][7], sh[2][4], sh[2][1:0], sh[3][0]} &
          {a[12], a[9], a[6], a[5], a[13]});
      expb = {d, e & ~d, p, 5'h00};
    end
  endfunction

  function ln(input [13:0] a);
    ln = sh[4][0] & (sh[0][6] & a[0] | sh[0][7] & a[1]);
  endfunction

  // one frame: alarms set, pulse, then the far end view compared
  task fr(input [13:0] a);
    begin
      alm <= a;
      frame_start <= 1'b1;
      @(posedge aclk) frame_start <= 1'b0;
      @(posedge aclk);
      chk("g1_byte", expb(a), g1_byte);
      chk("line_rdi", ln(a), line_seen);
    end
  endtask

  // configurations: line ctrl, path, enhanced, rx/enh, master
  task cfg(input integer s);
    reg [39:0] v;
    integer    k;
    begin
      case (s)
        0: v = {8'hc0, 8'hff, 8'hff, 8'hc3, 8'h00};
        1: v = {8'hc0, 8'hff, 8'hff, 8'hff, 8'h03};
        2: v = {8'h40, 8'h00, 8'h93, 8'h05, 8'h03};
        default: v = {8'h80, 8'hff, 8'hff, 8'hc3, 8'h01};
      endcase
      for (k = 0; k < 5; k = k + 1) begin
        sh[k] = v[39 - 8 * k -: 8];
        wr(8'h08 + k[7:0], sh[k], `RESP_OKAY);
      end
    end
  endtask

  task finish_test;
    begin
      if (mismatches == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  initial begin
    #400000;
    mismatches = mismatches + 1;
    finish_test;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08, `RST_LINE_RDI_CTRL, `RESP_OKAY);
    rd(8'h09, `RST_AUTO_PATH_RDI, `RESP_OKAY);
    rd(8'h0a, `RST_AUTO_ENH_RDI, `RESP_OKAY);
    rd(8'h0b, `RST_RX_RDI_ENH, `RESP_OKAY);
    rd(8'h0c, `RST_MASTER_CTRL, `RESP_OKAY);
    rd(8'h0d, 8'h00, `RESP_OKAY);
    rd(8'h20, 8'h00, `RESP_SLVERR);
    wr(8'h20, 8'hff, `RESP_SLVERR);
    for (c = 0; c < 4; c = c + 1) begin
      cfg(c);
      for (i = 0; i < 14; i = i + 1) begin
        fr(14'h1 << i);
        fr((14'h1 << i) | (14'h1 << ((i + 5) % 14)));
      end
      fr(14'h0);
    end
    cfg(1);
    rd(8'h0b, 8'hc7, `RESP_OKAY);
    fr(14'h0021);
    rd(8'h0d, 8'h0b, `RESP_OKAY);
    // enable low freezes decisions even across a frame pulse
    clk_en <= 1'b0;
    alm <= 14'h0;
    frame_start <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("frozen", {24'h0, expb(14'h0021)}, g1_byte);
    frame_start <= 1'b0;
    clk_en <= 1'b1;
    @(posedge aclk);
    finish_test;
  end
endmodule // auto_rdi_control_tb_top
